// [core/srg_pkg.sv]
// Purpose: Shared constants and types for the switch route gate and lock block.
// Assumes: Port 0 is the upstream port; ports 1 to 5 face downstream.
// Notes:   Both ends of the packet channel use these definitions.
package srg_pkg;

  // Port count and the width of a port number.
  localparam int unsigned NUM_PORTS = 6;
  localparam int unsigned PORT_W    = 3;

  // The upstream port number.
  localparam logic [PORT_W-1:0] UP_PORT = 3'h0;

  // Reset values of control state.
  localparam logic                 PEER_BLOCK_RST = 1'b0;
  localparam logic [NUM_PORTS-1:0] ROUTE_MASK_RST = 6'h00;
  localparam logic [PORT_W-1:0]    LOCK_PORT_RST  = 3'h0;

  // Packet kinds presented on the channel.
  typedef enum logic [3:0] {
    SRG_KIND_MWR    = 4'h0,
    SRG_KIND_MRD    = 4'h1,
    SRG_KIND_MRDLK  = 4'h2,
    SRG_KIND_CPL    = 4'h3,
    SRG_KIND_CPLDLK = 4'h4,
    SRG_KIND_CPLLK  = 4'h5,
    SRG_KIND_UNLOCK = 4'h6,
    SRG_KIND_MSG    = 4'h7,
    SRG_KIND_CFG    = 4'h8
  } srg_kind_t;

  // Lock state machine, one-hot.
  typedef enum logic [2:0] {
    SRG_ST_FREE   = 3'b001,
    SRG_ST_PORT   = 3'b010,
    SRG_ST_SWITCH = 3'b100
  } srg_lock_t;

  // One route-disable row: bit p blocks forwarding to port p.
  typedef logic [NUM_PORTS-1:0] srg_row_t;

endpackage

// [core/srg_if.sv]
// Purpose: Packet channel between the traffic side and the route gate.
// Assumes: Both parties run on the same switch core clock.
// Notes:   Requests stand until pkt_ready; results are one-cycle pulses.
`timescale 1ns/1ps
interface srg_if;

  // Request offered by the traffic side.
  logic                           pkt_valid;
  logic [srg_pkg::PORT_W-1:0]     pkt_src;
  logic [srg_pkg::PORT_W-1:0]     pkt_dst;
  srg_pkg::srg_kind_t             pkt_kind;
  logic                           pkt_local;
  logic [srg_pkg::NUM_PORTS-1:0]  posted_busy;

  // Answer from the gate.
  logic                           pkt_ready;
  logic                           res_fwd;
  logic                           res_ur;
  logic [srg_pkg::PORT_W-1:0]     res_port;

  // Lock state seen by the traffic side.
  logic                           port_locked;
  logic                           switch_locked;
  logic [srg_pkg::PORT_W-1:0]     lock_port;

  modport dev (
    input  pkt_valid, pkt_src, pkt_dst, pkt_kind, pkt_local, posted_busy,
    output pkt_ready, res_fwd, res_ur, res_port, port_locked, switch_locked, lock_port
  );

  modport root (
    output pkt_valid, pkt_src, pkt_dst, pkt_kind, pkt_local, posted_busy,
    input  pkt_ready, res_fwd, res_ur, res_port, port_locked, switch_locked, lock_port
  );

endinterface

// [core/srg_root.sv]
// Purpose: Traffic-side end that offers packets to the route gate.
// Assumes: The user side presents packets already queued in arrival order.
// Notes:   Root requests that the lock forbids are refused here, never offered.
`timescale 1ns/1ps
module srg_root (
  // Clock, reset and enable.
  input  wire logic                          i_clock,
  input  wire logic                          i_resetn,
  input  wire logic                          i_clk_en,
  // User-side packet request.
  input  wire logic                          i_valid,
  input  wire logic [srg_pkg::PORT_W-1:0]    i_src,
  input  wire logic [srg_pkg::PORT_W-1:0]    i_dst,
  input  wire srg_pkg::srg_kind_t            i_kind,
  input  wire logic                          i_local,
  input  wire logic [srg_pkg::NUM_PORTS-1:0] i_posted_busy,
  // User-side answer.
  output logic                               o_ready,
  output logic                               o_refused,
  output logic                               o_fwd,
  output logic                               o_ur,
  output logic [srg_pkg::PORT_W-1:0]         o_port,
  output logic                               o_switch_locked,
  // Channel to the gate.
  srg_if.root                                chan
);

  logic from_root;
  logic bad_kind;
  logic bad_port;
  logic refuse;
  logic refused_r;
  logic refused_nxt;

  // While switch-locked the root may only write, read locked or unlock; under either lock all but unlock must target the locked port or upstream.
  assign from_root = i_valid && !i_local && (i_src == srg_pkg::UP_PORT);
  assign bad_kind  = chan.switch_locked && from_root &&
                     !(i_kind == srg_pkg::SRG_KIND_MWR || i_kind == srg_pkg::SRG_KIND_MRDLK ||
                       i_kind == srg_pkg::SRG_KIND_UNLOCK);
  assign bad_port  = (chan.switch_locked || chan.port_locked) && from_root &&
                     (i_kind != srg_pkg::SRG_KIND_UNLOCK) &&
                     (i_dst != srg_pkg::UP_PORT) && (i_dst != chan.lock_port);
  assign refuse    = bad_kind || bad_port;

  // A refused packet is consumed at once so the user queue does not wedge.
  assign chan.pkt_valid   = i_valid && !refuse;
  assign chan.pkt_src     = i_src;
  assign chan.pkt_dst     = i_dst;
  assign chan.pkt_kind    = i_kind;
  assign chan.pkt_local   = i_local;
  assign chan.posted_busy = i_posted_busy;

  // A refusal only counts on an enabled edge, or its pulse would be lost while frozen.
  assign o_ready         = (refuse && i_clk_en) || chan.pkt_ready;
  assign o_fwd           = chan.res_fwd;
  assign o_ur            = chan.res_ur;
  assign o_port          = chan.res_port;
  assign o_switch_locked = chan.switch_locked;
  assign o_refused       = refused_r;

  // Refusal pulse, aligned with the gate's result pulses.
  assign refused_nxt = refuse;

  // The refusal flag is registered to match the gate's answer timing.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      refused_r <= 1'b0;
    end else if (i_clk_en) begin
      refused_r <= refused_nxt;
    end
  end

endmodule

// [core/srg_gate.sv]
// Purpose: Route permission and bus-lock control for a multi-port switch.
// Assumes: Port 0 is upstream; queue occupancy arrives as posted_busy flags.
// Notes:   Holding a packet is done by keeping pkt_ready low.
`timescale 1ns/1ps
module srg_gate (
  // Clock, reset and enable.
  input  wire logic                                         i_clock,
  input  wire logic                                         i_resetn,
  input  wire logic                                         i_clk_en,
  // Configuration from the switch control and route control registers.
  input  wire logic                                         i_peer_forward_block,
  input  wire logic [srg_pkg::NUM_PORTS*srg_pkg::NUM_PORTS-1:0] i_route_disable_mask,
  // Status for the switch status register.
  output logic                                              o_switch_locked_flag,
  output logic                                              o_port_locked,
  output logic [srg_pkg::PORT_W-1:0]                        o_lock_port,
  // Channel to the traffic side.
  srg_if.dev                                                chan
);

  // Registered configuration, one row per port.
  logic                 switch_control_reg_r;
  srg_pkg::srg_row_t    port_route_control_reg_r [srg_pkg::NUM_PORTS];

  // Lock state.
  srg_pkg::srg_lock_t           state_r;
  srg_pkg::srg_lock_t           state_nxt;
  logic [srg_pkg::PORT_W-1:0]   lock_port_r;
  logic [srg_pkg::PORT_W-1:0]   lock_port_nxt;

  // Result pulses.
  logic                         fwd_r;
  logic                         ur_r;
  logic [srg_pkg::PORT_W-1:0]   res_port_r;
  logic [srg_pkg::PORT_W-1:0]   res_port_nxt;

  // Request decode.
  logic src_up;
  logic dst_up;
  logic src_ok;
  logic dst_ok;
  logic self_route;
  logic peer_route;
  logic peer_ur;
  logic mask_bit;
  logic mask_ur;
  logic is_ur;
  logic st_free;
  logic st_port;
  logic st_switch;
  logic to_lock_port;
  logic from_lock_port;
  logic port_block;
  logic switch_block;
  logic order_stall;
  logic hold;
  logic take;
  logic take_fwd;
  logic lock_start;
  logic lock_grow;
  logic unlock_take;

  // Configuration capture; a row per port so each mask sits with its owner.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      switch_control_reg_r <= srg_pkg::PEER_BLOCK_RST;
    end else if (i_clk_en) begin
      switch_control_reg_r <= i_peer_forward_block;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < srg_pkg::NUM_PORTS; gp++) begin : g_row
      // Row gp blocks traffic leaving port gp toward the indexed ports.
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          port_route_control_reg_r[gp] <= srg_pkg::ROUTE_MASK_RST;
        end else if (i_clk_en) begin
          port_route_control_reg_r[gp] <=
            i_route_disable_mask[gp*srg_pkg::NUM_PORTS +: srg_pkg::NUM_PORTS];
        end
      end
    end
  endgenerate

  // Port classification of the offered packet.
  assign src_up     = (chan.pkt_src == srg_pkg::UP_PORT);
  assign dst_up     = (chan.pkt_dst == srg_pkg::UP_PORT);
  assign src_ok     = (chan.pkt_src < srg_pkg::PORT_W'(srg_pkg::NUM_PORTS));
  assign dst_ok     = (chan.pkt_dst < srg_pkg::PORT_W'(srg_pkg::NUM_PORTS));
  assign self_route = (chan.pkt_src == chan.pkt_dst);
  assign peer_route = !src_up && !dst_up && !self_route;

  // Only downstream-to-other-downstream routes are subject to either filter.
  assign peer_ur  = switch_control_reg_r && peer_route;
  assign mask_bit = (src_ok && dst_ok) ? port_route_control_reg_r[chan.pkt_src][chan.pkt_dst] : 1'b0;
  assign mask_ur  = mask_bit && peer_route;
  assign is_ur    = (peer_ur || mask_ur) && !chan.pkt_local;

  // Lock blocking; locally inserted messages are never blocked.
  assign st_free        = (state_r == srg_pkg::SRG_ST_FREE);
  assign st_port        = (state_r == srg_pkg::SRG_ST_PORT);
  assign st_switch      = (state_r == srg_pkg::SRG_ST_SWITCH);
  assign to_lock_port   = (chan.pkt_dst == lock_port_r);
  assign from_lock_port = (chan.pkt_src == lock_port_r);
  assign port_block     = !st_free && to_lock_port && !src_up && !chan.pkt_local;
  assign switch_block   = st_switch && !src_up && !from_lock_port && !chan.pkt_local &&
                          (dst_up || to_lock_port);

  // Ordering: a locked read, locked completion with data or unlock waits behind posted requests ahead of it.
  assign order_stall =
    ((chan.pkt_kind == srg_pkg::SRG_KIND_MRDLK) && dst_ok && chan.posted_busy[chan.pkt_dst]) ||
    ((chan.pkt_kind == srg_pkg::SRG_KIND_CPLDLK) && src_ok && chan.posted_busy[chan.pkt_src]) ||
    ((chan.pkt_kind == srg_pkg::SRG_KIND_UNLOCK) && chan.posted_busy[srg_pkg::UP_PORT]);

  // A held packet stays offered; nothing on the traffic side retires it.
  assign hold     = port_block || switch_block || order_stall;
  assign take     = chan.pkt_valid && !hold;
  assign take_fwd = take && !is_ur;

  // Lock events, each taken only from the party allowed to cause it.
  assign lock_start  = take_fwd && st_free && src_up && !dst_up &&
                       (chan.pkt_kind == srg_pkg::SRG_KIND_MRDLK);
  assign lock_grow   = take_fwd && st_port && from_lock_port &&
                       (chan.pkt_kind == srg_pkg::SRG_KIND_CPLDLK);
  assign unlock_take = take_fwd && src_up && !st_free &&
                       (chan.pkt_kind == srg_pkg::SRG_KIND_UNLOCK);

  // Next lock state; a failed completion leaves the port lock in place.
  always_comb begin
    state_nxt     = state_r;
    lock_port_nxt = lock_port_r;
    unique case (state_r)
      srg_pkg::SRG_ST_FREE: begin
        if (lock_start) begin
          state_nxt     = srg_pkg::SRG_ST_PORT;
          lock_port_nxt = chan.pkt_dst;
        end
      end
      srg_pkg::SRG_ST_PORT: begin
        if (unlock_take) begin
          state_nxt     = srg_pkg::SRG_ST_FREE;
          lock_port_nxt = srg_pkg::LOCK_PORT_RST;
        end else if (lock_grow) begin
          state_nxt = srg_pkg::SRG_ST_SWITCH;
        end
      end
      srg_pkg::SRG_ST_SWITCH: begin
        if (unlock_take) begin
          state_nxt     = srg_pkg::SRG_ST_FREE;
          lock_port_nxt = srg_pkg::LOCK_PORT_RST;
        end
      end
      default: begin
        state_nxt     = srg_pkg::SRG_ST_FREE;
        lock_port_nxt = srg_pkg::LOCK_PORT_RST;
      end
    endcase
  end

  // Unlock goes to whichever port holds the lock, whatever its address says.
  assign res_port_nxt = unlock_take ? lock_port_r : chan.pkt_dst;

  // Lock state registers; nothing else in the switch changes them.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r     <= srg_pkg::SRG_ST_FREE;
      lock_port_r <= srg_pkg::LOCK_PORT_RST;
    end else if (i_clk_en) begin
      state_r     <= state_nxt;
      lock_port_r <= lock_port_nxt;
    end
  end

  // Result pulses for each taken packet.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fwd_r      <= 1'b0;
      ur_r       <= 1'b0;
      res_port_r <= srg_pkg::LOCK_PORT_RST;
    end else if (i_clk_en) begin
      fwd_r      <= take_fwd;
      ur_r       <= take && is_ur;
      res_port_r <= res_port_nxt;
    end
  end

  // Channel answer. Ready is combinational so a hold costs no extra cycle.
  assign chan.pkt_ready     = !hold && i_clk_en;
  assign chan.res_fwd       = fwd_r;
  assign chan.res_ur        = ur_r;
  assign chan.res_port      = res_port_r;
  assign chan.port_locked   = st_port;
  assign chan.switch_locked = st_switch;
  assign chan.lock_port     = lock_port_r;

  // Status is a plain level; the sideband path never passes through this gate.
  assign o_switch_locked_flag = st_switch;
  assign o_port_locked        = st_port;
  assign o_lock_port          = lock_port_r;

endmodule

// [verif/srg_chan_sva.sv]
// Purpose: Concurrent checks on the packet channel between root end and gate.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Only channel signals are seen, so config effects are left to the bench.
`timescale 1ns/1ps
module srg_chan_sva (
  // Clock and reset.
  input wire logic                          i_clock,
  input wire logic                          i_resetn,
  // Request from the root end.
  input wire logic                          pkt_valid,
  input wire logic [srg_pkg::PORT_W-1:0]    pkt_src,
  input wire logic [srg_pkg::PORT_W-1:0]    pkt_dst,
  input wire srg_pkg::srg_kind_t            pkt_kind,
  input wire logic                          pkt_local,
  input wire logic [srg_pkg::NUM_PORTS-1:0] posted_busy,
  // Answer and lock state from the gate.
  input wire logic                          pkt_ready,
  input wire logic                          res_fwd,
  input wire logic                          res_ur,
  input wire logic [srg_pkg::PORT_W-1:0]    res_port,
  input wire logic                          port_locked,
  input wire logic                          switch_locked,
  input wire logic [srg_pkg::PORT_W-1:0]    lock_port
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // Decodes kept as wires so each property stays readable.
  logic take, idle, rdlk, cpld, unlk, barred;
  assign take = pkt_valid && pkt_ready;
  assign idle = !port_locked && !switch_locked;
  assign rdlk = pkt_kind == srg_pkg::SRG_KIND_MRDLK;
  assign cpld = pkt_kind == srg_pkg::SRG_KIND_CPLDLK;
  assign unlk = pkt_kind == srg_pkg::SRG_KIND_UNLOCK;
  // Non-root, non-local traffic that the lock must hold back.
  assign barred = pkt_valid && !pkt_local && pkt_src != 3'h0 &&
                  ((!idle && pkt_dst == lock_port) || (switch_locked && pkt_src != lock_port && pkt_dst == 3'h0));

  a_take_answer: assert property (take |=> res_fwd != res_ur)
    else $error("taken packet not answered exactly once");
  a_lock_single: assert property (!(port_locked && switch_locked))
    else $error("port and switch lock both set");
  a_lock_start: assert property (take && rdlk && pkt_src == 3'h0 && pkt_dst != 3'h0 && idle
    |=> port_locked && lock_port == $past(pkt_dst)) else $error("locked read did not lock its port");
  a_lock_grow: assert property (take && cpld && port_locked && pkt_src == lock_port
    |=> switch_locked && $stable(lock_port)) else $error("locked completion did not lock switch");
  a_unlock_clear: assert property (take && unlk && pkt_src == 3'h0 && !idle
    |=> idle && res_fwd && res_port == $past(lock_port)) else $error("unlock did not clear lock");
  a_lock_hold: assert property (barred |-> !pkt_ready)
    else $error("blocked packet was accepted");
  a_rdlk_order: assert property (pkt_valid && rdlk && posted_busy[pkt_dst] |-> !pkt_ready)
    else $error("locked read passed queued posted requests");
  a_cpl_order: assert property (pkt_valid && cpld && posted_busy[pkt_src] |-> !pkt_ready)
    else $error("locked completion passed queued posted requests");
  a_unlock_order: assert property (pkt_valid && unlk && posted_busy[0] |-> !pkt_ready)
    else $error("unlock passed queued posted requests");
  a_lock_steady: assert property (take && switch_locked && !unlk |=> switch_locked && $stable(lock_port))
    else $error("lock state changed by locked traffic");
  a_other_free: assert property (port_locked && pkt_valid && pkt_dst != lock_port && !barred
    && pkt_kind == srg_pkg::SRG_KIND_MWR |-> pkt_ready) else $error("port lock blocked other traffic");

  // Main scenarios.
  c_switch_lock: cover property ($rose(switch_locked));
  c_unlock: cover property (take && unlk && switch_locked);
  c_ur: cover property (res_ur);
endmodule

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the route gate facing the root end.
// Assumes: Port 0 is upstream; answers reach the user side one cycle after a take.
// Notes:   Clock enable is dropped once, to show that a frozen gate holds its packet.
`timescale 1ns/1ps
module tb_top;
  // Result codes held in the expectation queue beside the port.
  localparam logic [1:0] FW = 2'd0;
  localparam logic [1:0] UR = 2'd1;
  localparam logic [1:0] RF = 2'd2;
  logic               clk, clk_en, resetn, pfb, valid, loc, o_ready, o_refused, o_fwd, o_ur, o_swl, flag, plk;
  logic [2:0]         src, dst, o_port, lport, s, d;
  logic [5:0]         busy;
  logic [35:0]        mask;
  srg_pkg::srg_kind_t kind;
  logic [4:0]         expq[$];
  int                 n_fail, n_checks, seed, i;

  srg_if chan ();
  srg_root srg_root_i (.i_clock(clk), .i_resetn(resetn), .i_clk_en(clk_en), .i_valid(valid), .i_src(src),
    .i_dst(dst), .i_kind(kind), .i_local(loc), .i_posted_busy(busy), .o_ready(o_ready), .o_refused(o_refused),
    .o_fwd(o_fwd), .o_ur(o_ur), .o_port(o_port), .o_switch_locked(o_swl), .chan(chan));
  srg_gate srg_gate_i (.i_clock(clk), .i_resetn(resetn), .i_clk_en(clk_en), .i_peer_forward_block(pfb),
    .i_route_disable_mask(mask), .o_switch_locked_flag(flag), .o_port_locked(plk), .o_lock_port(lport),
    .chan(chan));
  srg_chan_sva srg_chan_sva_i (.i_clock(clk), .i_resetn(resetn), .pkt_valid(chan.pkt_valid),
    .pkt_src(chan.pkt_src), .pkt_dst(chan.pkt_dst), .pkt_kind(chan.pkt_kind), .pkt_local(chan.pkt_local),
    .posted_busy(chan.posted_busy), .pkt_ready(chan.pkt_ready), .res_fwd(chan.res_fwd), .res_ur(chan.res_ur),
    .res_port(chan.res_port), .port_locked(chan.port_locked), .switch_locked(chan.switch_locked),
    .lock_port(chan.lock_port));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Routing result: the port is ignored for a refusal, which carries none.
  task automatic check_res(input logic [4:0] e, input logic [4:0] g);
    n_checks++;
    if (e[4:3] !== g[4:3] || (e[4:3] != RF && e[2:0] !== g[2:0])) begin
      n_fail++;
      $display("CHECK FAILED at %0t: result %h expected %h", $time, g, e);
    end
  endtask

  // Level comparison for lock state and ready.
  task automatic check_lvl(input logic [4:0] e, input logic [4:0] g);
    n_checks++;
    if (e !== g) begin
      n_fail++;
      $display("CHECK FAILED at %0t: level %h expected %h", $time, g, e);
    end
  endtask

  task automatic offer(input logic [2:0] ps, pd, input srg_pkg::srg_kind_t k, input logic l, input logic [5:0] b);
    @(negedge clk);
    valid = 1'b1;
    src = ps;
    dst = pd;
    kind = k;
    loc = l;
    busy = b;
  endtask

  // Holds the request until ready, bounded so a hang ends the run.
  task automatic take();
    int n;
    n = 0;
    #1;
    while (o_ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n == 40) begin
      n_fail++;
      $display("CHECK FAILED at %0t: ready never came", $time);
      end_of_test();
    end
    @(negedge clk);
    valid = 1'b0;
  endtask

  task automatic send(input logic [2:0] ps, pd, input srg_pkg::srg_kind_t k, input logic l, input logic [4:0] e);
    offer(ps, pd, k, l, 6'h00);
    expq.push_back(e);
    take();
  endtask

  // Posted traffic still queued must hold the packet back until it drains.
  task automatic stall(input logic [2:0] ps, pd, input srg_pkg::srg_kind_t k, input logic [5:0] b,
                       input logic [4:0] e);
    offer(ps, pd, k, 1'b0, b);
    expq.push_back(e);
    repeat (4) @(negedge clk);
    check_lvl(5'h00, {4'h0, o_ready});
    busy = 6'h00;
    take();
  endtask

  // Every result pulse is matched against the oldest expectation.
  always @(negedge clk) begin
    if (resetn && (o_fwd || o_ur || o_refused)) begin
      check_res(expq.size() ? expq.pop_front() : 5'h1f, {o_refused, o_ur, o_port});
    end
  end

  initial begin
    seed = 18724;
    clk_en = 1'b1;
    resetn = 1'b0;
    valid = 1'b0;
    src = 3'h0;
    dst = 3'h0;
    kind = srg_pkg::SRG_KIND_MWR;
    loc = 1'b0;
    busy = 6'h00;
    pfb = 1'b0;
    mask = 36'h0_0000_0000;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    check_lvl(5'h00, {flag, plk, lport});
    send(3'd1, 3'd2, srg_pkg::SRG_KIND_MWR, 1'b0, {FW, 3'd2});
    // A frozen clock enable must hold an offered packet without losing it.
    offer(3'h1, 3'h2, srg_pkg::SRG_KIND_MWR, 1'b0, 6'h00);
    clk_en = 1'b0;
    expq.push_back({FW, 3'h2});
    repeat (3) @(negedge clk);
    check_lvl(5'h00, {4'h0, o_ready});
    clk_en = 1'b1;
    take();
    pfb = 1'b1;
    repeat (2) @(negedge clk);
    send(3'd1, 3'd2, srg_pkg::SRG_KIND_MWR, 1'b0, {UR, 3'd2});
    send(3'd1, 3'd0, srg_pkg::SRG_KIND_MWR, 1'b0, {FW, 3'd0});
    pfb = 1'b0;
    mask = 36'({$random(seed), $random(seed)});
    repeat (2) @(negedge clk);
    for (i = 0; i < 20; i++) begin
      s = 3'($unsigned($random(seed)) % 6);
      d = 3'($unsigned($random(seed)) % 6);
      send(s, d, srg_pkg::SRG_KIND_MWR, 1'b0, {1'b0, s != 0 && d != 0 && s != d && mask[s*6+d], d});
    end
    mask = 36'h0_0000_0000;
    stall(3'd0, 3'd3, srg_pkg::SRG_KIND_MRDLK, 6'h08, {FW, 3'd3});
    check_lvl({2'b01, 3'd3}, {flag, plk, lport});
    send(3'd1, 3'd0, srg_pkg::SRG_KIND_MWR, 1'b0, {FW, 3'd0});
    send(3'd2, 3'd4, srg_pkg::SRG_KIND_MWR, 1'b0, {FW, 3'd4});
    stall(3'd3, 3'd0, srg_pkg::SRG_KIND_CPLDLK, 6'h08, {FW, 3'd0});
    check_lvl({2'b10, 3'd3}, {flag, plk, lport});
    check_lvl(5'h01, {4'h0, o_swl});
    send(3'd0, 3'd3, srg_pkg::SRG_KIND_MWR, 1'b0, {FW, 3'd3});
    send(3'd0, 3'd3, srg_pkg::SRG_KIND_MRDLK, 1'b0, {FW, 3'd3});
    send(3'd3, 3'd0, srg_pkg::SRG_KIND_CPLLK, 1'b0, {FW, 3'd0});
    send(3'd3, 3'd0, srg_pkg::SRG_KIND_MSG, 1'b1, {FW, 3'd0});
    send(3'd0, 3'd3, srg_pkg::SRG_KIND_CFG, 1'b0, {RF, 3'd0});
    send(3'd0, 3'd3, srg_pkg::SRG_KIND_MRD, 1'b0, {RF, 3'd0});
    send(3'd0, 3'd2, srg_pkg::SRG_KIND_MWR, 1'b0, {RF, 3'd0});
    check_lvl({2'b10, 3'd3}, {flag, plk, lport});
    stall(3'd0, 3'd3, srg_pkg::SRG_KIND_UNLOCK, 6'h01, {FW, 3'd3});
    check_lvl(5'h00, {flag, plk, lport});
    send(3'd0, 3'd2, srg_pkg::SRG_KIND_MRDLK, 1'b0, {FW, 3'd2});
    send(3'd2, 3'd0, srg_pkg::SRG_KIND_CPLLK, 1'b0, {FW, 3'd0});
    check_lvl({2'b01, 3'd2}, {flag, plk, lport});
    send(3'd0, 3'd2, srg_pkg::SRG_KIND_UNLOCK, 1'b0, {FW, 3'd2});
    check_lvl(5'h00, {flag, plk, lport});
    send(3'd0, 3'd4, srg_pkg::SRG_KIND_MRDLK, 1'b0, {FW, 3'd4});
    send(3'd4, 3'd0, srg_pkg::SRG_KIND_CPLDLK, 1'b0, {FW, 3'd0});
    // A held packet cannot be withdrawn, so a mid-run reset ends the hold.
    offer(3'd1, 3'd0, srg_pkg::SRG_KIND_MWR, 1'b0, 6'h00);
    repeat (8) begin
      @(negedge clk);
      check_lvl(5'h00, {4'h0, o_ready});
    end
    resetn = 1'b0;
    valid = 1'b0;
    repeat (3) @(negedge clk);
    check_lvl(5'h00, {flag, plk, lport});
    resetn = 1'b1;
    send(3'd1, 3'd0, srg_pkg::SRG_KIND_MWR, 1'b0, {FW, 3'd0});
    repeat (3) @(negedge clk);
    check_lvl(5'h00, 5'(expq.size()));
    end_of_test();
  end
endmodule
